// [common/tmic_pkg.sv]
// constants for the timer interrupt mask, flag and capture block
package tmic_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam logic [7:0] TMIC_IO_DATA_OFS   = 8'h20;
  localparam logic [7:0] TMIC_IO_FLAGS      = 8'h36;
  localparam logic [7:0] TMIC_IO_MASK       = 8'h37;
  localparam logic [7:0] TMIC_IO_CAP1_LO    = 8'h26;
  localparam logic [7:0] TMIC_IO_CAP1_HI    = 8'h27;
  localparam logic [7:0] TMIC_ADDR_FLAGS    = TMIC_IO_FLAGS + TMIC_IO_DATA_OFS;
  localparam logic [7:0] TMIC_ADDR_MASK     = TMIC_IO_MASK + TMIC_IO_DATA_OFS;
  localparam logic [7:0] TMIC_ADDR_CAP1_LO  = TMIC_IO_CAP1_LO + TMIC_IO_DATA_OFS;
  localparam logic [7:0] TMIC_ADDR_CAP1_HI  = TMIC_IO_CAP1_HI + TMIC_IO_DATA_OFS;
  localparam logic [7:0] TMIC_ADDR_EFLAGS   = 8'h7C;
  localparam logic [7:0] TMIC_ADDR_EMASK    = 8'h7D;
  localparam logic [7:0] TMIC_ADDR_CAP3_LO  = 8'h80;
  localparam logic [7:0] TMIC_ADDR_CAP3_HI  = 8'h81;

  // ****************************************
  // field positions
  // ****************************************
  localparam int TMIC_BIT_CAP     = 5;
  localparam int TMIC_BIT_CMPA    = 4;
  localparam int TMIC_BIT_CMPB    = 3;
  localparam int TMIC_BIT_OVF     = 2;
  localparam int TMIC_BIT_T3_CMPC = 1;
  localparam int TMIC_BIT_T1_CMPC = 0;
  localparam logic [7:0] TMIC_MASK_VALID   = 8'h3C;
  localparam logic [7:0] TMIC_EMASK_VALID  = 8'h3F;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  TMIC_RST_BYTE = 8'h00;
  localparam logic [15:0] TMIC_RST_WORD = 16'h0000;

endpackage

// [common/tmic_cap_if.sv]
// link between the register logic and one capture unit
`timescale 1ns/1ps
`default_nettype none
interface tmic_cap_if;
  logic [15:0] cap_value;
  logic        cap_event;
  logic        sw_we;
  logic [15:0] sw_wdata;

  modport unit (output cap_value, output cap_event, input sw_we, input sw_wdata);
  modport host (input cap_value, input cap_event, output sw_we, output sw_wdata);
endinterface
`default_nettype wire

// [src/tmic_capture.sv]
// input capture register of one 16-bit timer
`timescale 1ns/1ps
`default_nettype none
module tmic_capture
  import tmic_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        pin_level,
  input  wire logic        alt_level,
  input  wire logic        use_alt,
  input  wire logic        top_is_capture,
  input  wire logic        counter_at_top,
  input  wire logic [15:0] counter_value,
  tmic_cap_if.unit         cap
);

  // ****************************************
  // capture source edge
  // ****************************************
  logic        src_prev_r;
  logic        src_now;
  logic        src_edge;
  logic [15:0] cap_value_r;

  assign src_now  = use_alt ? alt_level : pin_level;
  assign src_edge = src_now & ~src_prev_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_now;
    end
  end

  // ****************************************
  // capture register
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cap_value_r <= TMIC_RST_WORD;
    end else if (src_edge && !top_is_capture) begin
      cap_value_r <= counter_value;
    end else if (cap.sw_we) begin
      cap_value_r <= cap.sw_wdata;
    end
  end

  assign cap.cap_value = cap_value_r;
  // flag source: counter at top while the register serves as top
  assign cap.cap_event = top_is_capture ? counter_at_top : src_edge;

endmodule // tmic_capture
`default_nettype wire

// [src/tmic_top.sv]
// timer interrupt masks, flags and capture registers of timers 1 and 3
//
// Behaviour
// - capture event copies the counter into that timer's capture register, except in capture-top mode
// - capture register is offered as counter top value
// - 16-bit capture access goes through one shared 8-bit high-byte holding register
// - timer 1 capture request needs mask bit 5, global enable and flag
// - timer 1 compare A request needs mask bit 4, global enable and flag
// - timer 1 compare B request needs mask bit 3, global enable and flag
// - timer 1 overflow request needs mask bit 2, global enable and flag
// - extended mask bits 5..1 enable timer 3 capture, A, B, overflow, C
// - extended mask bit 0 enables timer 1 compare C request
// - extended mask is absent in legacy compatibility mode
// - capture flag sets on capture event, or at top in capture-top mode
// - capture flag clears on vector execution or write of one
// - compare A flag sets one cycle after a ticked match
// - forced compare strobe never sets a compare flag
// - compare A flag clears on vector execution or write of one
// - compare B flag sets after match, not by force, clears like others
// - overflow flag sets on overflow, clears on vector or write of one
// - extended flags hold timer 3 bits 5..1 and timer 1 compare C in bit 0
`timescale 1ns/1ps
`default_nettype none
module tmic_top
  import tmic_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_we,
  input  wire logic        io_re,
  output var  logic [7:0]  io_rdata,
  input  wire logic        global_irq_en,
  input  wire logic        compat_mode,
  input  wire logic [15:0] counter1_value,
  input  wire logic [15:0] counter3_value,
  input  wire logic        t1_capture_input_pin,
  input  wire logic        t3_capture_input_pin,
  input  wire logic        t1_comparator_out,
  input  wire logic        t1_capture_from_comparator,
  input  wire logic        t1_top_is_capture,
  input  wire logic        t3_top_is_capture,
  input  wire logic        t1_counter_at_top,
  input  wire logic        t3_counter_at_top,
  input  wire logic        t1_tick,
  input  wire logic        t3_tick,
  input  wire logic [2:0]  t1_cmp_match,
  input  wire logic [2:0]  t1_force_cmp,
  input  wire logic [2:0]  t3_cmp_match,
  input  wire logic [2:0]  t3_force_cmp,
  input  wire logic        t1_overflow,
  input  wire logic        t3_overflow,
  input  wire logic [7:0]  flags_vec_ack,
  input  wire logic [7:0]  eflags_vec_ack,
  output var  logic [7:0]  irq_req,
  output var  logic [7:0]  ext_irq_req,
  output var  logic [15:0] capture1_top,
  output var  logic [15:0] capture3_top
);

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] eflags_r;
  logic [7:0] eflags_nxt;
  logic [7:0] mask_r;
  logic [7:0] emask_r;
  logic [7:0] emask_eff;
  logic [7:0] temp_r;
  logic [7:0] rdata_r;
  logic [7:0] rd_val;
  logic [7:0] flags_set;
  logic [7:0] eflags_set;
  logic [7:0] flags_wclr;
  logic [7:0] eflags_wclr;
  logic [2:0] t1_cmp_seen_r;
  logic [2:0] t3_cmp_seen_r;
  logic       t1_ovf_seen_r;
  logic       t3_ovf_seen_r;
  logic [7:0] irq_r;
  logic [7:0] ext_irq_r;

  tmic_cap_if cap1 ();
  tmic_cap_if cap3 ();

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] flag_next(
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic [7:0] wclr,
    input logic [7:0] ack,
    input logic [7:0] valid
  );
    flag_next = ((cur & ~(wclr | ack)) | set) & valid;
  endfunction

  function automatic logic [7:0] irq_gate(
    input logic [7:0] flags,
    input logic [7:0] mask,
    input logic       gie
  );
    irq_gate = flags & mask & {8{gie}};
  endfunction

  // ****************************************
  // capture units
  // ****************************************
  tmic_capture u_cap1 (
    .clock          (clock),
    .rst_n          (rst_n),
    .pin_level      (t1_capture_input_pin),
    .alt_level      (t1_comparator_out),
    .use_alt        (t1_capture_from_comparator),
    .top_is_capture (t1_top_is_capture),
    .counter_at_top (t1_counter_at_top),
    .counter_value  (counter1_value),
    .cap            (cap1.unit)
  );

  tmic_capture u_cap3 (
    .clock          (clock),
    .rst_n          (rst_n),
    .pin_level      (t3_capture_input_pin),
    .alt_level      (1'b0),
    .use_alt        (1'b0),
    .top_is_capture (t3_top_is_capture),
    .counter_at_top (t3_counter_at_top),
    .counter_value  (counter3_value),
    .cap            (cap3.unit)
  );

  // low byte write commits the held high byte with it
  assign cap1.sw_we    = io_we && (io_addr == TMIC_ADDR_CAP1_LO);
  assign cap1.sw_wdata = {temp_r, io_wdata};
  assign cap3.sw_we    = io_we && (io_addr == TMIC_ADDR_CAP3_LO);
  assign cap3.sw_wdata = {temp_r, io_wdata};

  // ****************************************
  // event qualification
  // ****************************************
  // forced strobes are masked out before the match is seen
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      t1_cmp_seen_r <= 3'h0;
      t3_cmp_seen_r <= 3'h0;
    end else begin
      t1_cmp_seen_r <= t1_cmp_match & ~t1_force_cmp & {3{t1_tick}};
      t3_cmp_seen_r <= t3_cmp_match & ~t3_force_cmp & {3{t3_tick}};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      t1_ovf_seen_r <= 1'b0;
      t3_ovf_seen_r <= 1'b0;
    end else begin
      t1_ovf_seen_r <= t1_overflow & t1_tick;
      t3_ovf_seen_r <= t3_overflow & t3_tick;
    end
  end

  always_comb begin
    flags_set                  = 8'h00;
    flags_set[TMIC_BIT_CAP]    = cap1.cap_event;
    flags_set[TMIC_BIT_CMPA]   = t1_cmp_seen_r[0];
    flags_set[TMIC_BIT_CMPB]   = t1_cmp_seen_r[1];
    flags_set[TMIC_BIT_OVF]    = t1_ovf_seen_r;
  end

  always_comb begin
    eflags_set                   = 8'h00;
    eflags_set[TMIC_BIT_CAP]     = cap3.cap_event;
    eflags_set[TMIC_BIT_CMPA]    = t3_cmp_seen_r[0];
    eflags_set[TMIC_BIT_CMPB]    = t3_cmp_seen_r[1];
    eflags_set[TMIC_BIT_OVF]     = t3_ovf_seen_r;
    eflags_set[TMIC_BIT_T3_CMPC] = t3_cmp_seen_r[2];
    eflags_set[TMIC_BIT_T1_CMPC] = t1_cmp_seen_r[2];
  end

  // ****************************************
  // flag registers
  // ****************************************
  assign flags_wclr  = (io_we && io_addr == TMIC_ADDR_FLAGS) ? io_wdata : 8'h00;
  assign eflags_wclr = (io_we && io_addr == TMIC_ADDR_EFLAGS) ? io_wdata : 8'h00;
  // write one or vector execution clears, set still wins
  assign flags_nxt  = flag_next(flags_r, flags_set, flags_wclr, flags_vec_ack,
                                TMIC_MASK_VALID);
  assign eflags_nxt = flag_next(eflags_r, eflags_set, eflags_wclr, eflags_vec_ack,
                                TMIC_EMASK_VALID);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= TMIC_RST_BYTE;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eflags_r <= TMIC_RST_BYTE;
    end else begin
      eflags_r <= eflags_nxt;
    end
  end

  // ****************************************
  // mask registers
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= TMIC_RST_BYTE;
    end else if (io_we && io_addr == TMIC_ADDR_MASK) begin
      mask_r <= io_wdata & TMIC_MASK_VALID;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      emask_r <= TMIC_RST_BYTE;
    end else if (compat_mode) begin
      emask_r <= TMIC_RST_BYTE;
    end else if (io_we && io_addr == TMIC_ADDR_EMASK) begin
      emask_r <= io_wdata & TMIC_EMASK_VALID;
    end
  end

  assign emask_eff = compat_mode ? 8'h00 : emask_r;

  // ****************************************
  // shared high-byte holding register
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      temp_r <= TMIC_RST_BYTE;
    end else if (io_we && (io_addr == TMIC_ADDR_CAP1_HI || io_addr == TMIC_ADDR_CAP3_HI)) begin
      temp_r <= io_wdata;
    end else if (io_re && io_addr == TMIC_ADDR_CAP1_LO) begin
      temp_r <= cap1.cap_value[15:8];
    end else if (io_re && io_addr == TMIC_ADDR_CAP3_LO) begin
      temp_r <= cap3.cap_value[15:8];
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // data-space addresses only; low registers sit at port offset plus 0x20
  always_comb begin
    if (io_addr == TMIC_ADDR_FLAGS) begin
      rd_val = flags_r;
    end else if (io_addr == TMIC_ADDR_MASK) begin
      rd_val = mask_r;
    end else if (io_addr == TMIC_ADDR_EFLAGS) begin
      rd_val = eflags_r;
    end else if (io_addr == TMIC_ADDR_EMASK) begin
      rd_val = emask_eff;
    end else if (io_addr == TMIC_ADDR_CAP1_LO) begin
      rd_val = cap1.cap_value[7:0];
    end else if (io_addr == TMIC_ADDR_CAP1_HI) begin
      rd_val = temp_r;
    end else if (io_addr == TMIC_ADDR_CAP3_LO) begin
      rd_val = cap3.cap_value[7:0];
    end else if (io_addr == TMIC_ADDR_CAP3_HI) begin
      rd_val = temp_r;
    end else begin
      rd_val = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= TMIC_RST_BYTE;
    end else if (io_re) begin
      rdata_r <= rd_val;
    end
  end

  assign io_rdata = rdata_r;

  // ****************************************
  // interrupt requests
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= TMIC_RST_BYTE;
    end else begin
      irq_r <= irq_gate(flags_r, mask_r, global_irq_en);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_r <= TMIC_RST_BYTE;
    end else begin
      ext_irq_r <= irq_gate(eflags_r, emask_eff, global_irq_en);
    end
  end

  assign irq_req      = irq_r;
  assign ext_irq_req  = ext_irq_r;
  assign capture1_top = cap1.cap_value;
  assign capture3_top = cap3.cap_value;

endmodule // tmic_top
`default_nettype wire

// [testbench/tmic_properties.sv]
// port assertions for the timer interrupt mask, flag and capture block
`timescale 1ns/1ps
`default_nettype none
module tmic_properties (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        io_we,
  input wire logic        io_re,
  input wire logic [7:0]  io_rdata,
  input wire logic        global_irq_en,
  input wire logic        compat_mode,
  input wire logic [15:0] counter1_value,
  input wire logic [15:0] counter3_value,
  input wire logic        t3_capture_input_pin,
  input wire logic        t1_comparator_out,
  input wire logic        t1_capture_from_comparator,
  input wire logic        t1_top_is_capture,
  input wire logic        t3_top_is_capture,
  input wire logic [7:0]  irq_req,
  input wire logic [7:0]  ext_irq_req,
  input wire logic [15:0] capture1_top,
  input wire logic [15:0] capture3_top
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_gie;
    !$past(global_irq_en) |-> irq_req == 8'h00 && ext_irq_req == 8'h00;
  endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_unused;
    irq_req[7:6] == 2'h0 && irq_req[1:0] == 2'h0 && ext_irq_req[7:6] == 2'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("request on unused bit");
  property p_compat;
    $past(compat_mode) && $past(compat_mode, 2) |-> ext_irq_req == 8'h00;
  endproperty
  a_compat: assert property (p_compat) else $error("extended request in legacy mode");
  property p_hold;
    !$past(io_re) |-> $stable(io_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_cap3;
    $rose(t3_capture_input_pin) && !t3_top_is_capture && !io_we
      |=> capture3_top == $past(counter3_value);
  endproperty
  a_cap3: assert property (p_cap3) else $error("timer 3 capture value wrong");
  property p_cap1;
    $rose(t1_comparator_out) && t1_capture_from_comparator && !t1_top_is_capture && !io_we
      |=> capture1_top == $past(counter1_value);
  endproperty
  a_cap1: assert property (p_cap1) else $error("timer 1 capture value wrong");
  property p_top_ign;
    $rose(t3_capture_input_pin) && t3_top_is_capture && !io_we |=> $stable(capture3_top);
  endproperty
  a_top_ign: assert property (p_top_ign) else $error("capture in top mode");
  property p_cap3_quiet;
    !$past(io_we) && !($past(t3_capture_input_pin) && !$past(t3_capture_input_pin, 2))
      |-> $stable(capture3_top);
  endproperty
  a_cap3_quiet: assert property (p_cap3_quiet) else $error("capture moved without cause");

  cover property ($rose(irq_req[4]));
  cover property ($rose(ext_irq_req[5]));
  cover property (io_re ##2 io_re);
endmodule // tmic_properties
bind tmic_top tmic_properties tmic_properties_inst (.*);
`default_nettype wire

// [testbench/tmic_cpu_model.sv]
// cpu interrupt logic model: acknowledges the lowest pending vector
`timescale 1ns/1ps
`default_nettype none
module tmic_cpu_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ack_en,
  input  wire logic       slow,
  input  wire logic [7:0] irq_req,
  input  wire logic [7:0] ext_irq_req,
  output var  logic [7:0] flags_vec_ack,
  output var  logic [7:0] eflags_vec_ack
);
  logic [3:0] wait_r;
  // hold off after a vector: the request drops two edges after the ack
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_vec_ack  <= 8'h00;
      eflags_vec_ack <= 8'h00;
      wait_r         <= 4'h0;
    end else begin
      flags_vec_ack  <= 8'h00;
      eflags_vec_ack <= 8'h00;
      if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else if (ack_en && irq_req != 8'h00) begin
        flags_vec_ack <= irq_req & (~irq_req + 8'h01);
        wait_r        <= slow ? 4'h9 : 4'h3;
      end else if (ack_en && ext_irq_req != 8'h00) begin
        eflags_vec_ack <= ext_irq_req & (~ext_irq_req + 8'h01);
        wait_r         <= slow ? 4'h9 : 4'h3;
      end
    end
  end
endmodule // tmic_cpu_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the timer interrupt block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tmic_pkg::*;
  logic clock, rst_n, io_we, io_re, global_irq_en, compat_mode, ack_en, slow;
  logic [7:0] io_addr, io_wdata, io_rdata, irq_req, ext_irq_req, flags_vec_ack, eflags_vec_ack;
  logic [15:0] counter1_value, counter3_value, capture1_top, capture3_top;
  logic t1_capture_input_pin, t3_capture_input_pin, t1_comparator_out;
  logic t1_capture_from_comparator, t1_top_is_capture, t3_top_is_capture;
  logic t1_counter_at_top, t3_counter_at_top, t1_tick, t3_tick, t1_overflow, t3_overflow;
  logic [2:0] t1_cmp_match, t1_force_cmp, t3_cmp_match, t3_force_cmp;
  int num_errors, n_compared, cycles;
  logic [7:0] ea [8] = '{8'h56, 8'h56, 8'h56, 8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7C};
  int eb [8] = '{4, 3, 2, 0, 5, 3, 2, 1};

  tmic_top tmic_top_inst (.*);
  tmic_cpu_model tmic_cpu_model_inst (.*);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    io_addr <= a;
    io_wdata <= v;
    io_we <= 1'b1;
    @(posedge clock);
    io_we <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    io_addr <= a;
    io_re <= 1'b1;
    @(posedge clock);
    io_re <= 1'b0;
    @(negedge clock);
    chk($sformatf("reg %h", a), e, io_rdata);
  endtask
  task automatic tick1(input logic [2:0] m, input logic [2:0] f, input logic ov);
    @(posedge clock);
    t1_cmp_match <= m;
    t1_force_cmp <= f;
    t1_overflow <= ov;
    t1_tick <= 1'b1;
    @(posedge clock);
    {t1_cmp_match, t1_force_cmp, t1_overflow, t1_tick} <= '0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    foreach (ea[i]) rchk(ea[i], 8'h00);
    rchk(8'h80, 8'h00);
    wr(8'h57, 8'hFF);
    rchk(8'h57, 8'h3C);
    wr(8'h7D, 8'hFF);
    rchk(8'h7D, 8'h3F);
    wr(8'h90, 8'hFF);
    rchk(8'h90, 8'h00);
  endtask
  task automatic t_events;
    global_irq_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      case (i)
        0: t1_cmp_match <= 3'h1;
        1: t1_cmp_match <= 3'h2;
        2: t1_overflow <= 1'b1;
        3: t1_cmp_match <= 3'h4;
        4: t3_capture_input_pin <= 1'b1;
        5: t3_cmp_match <= 3'h2;
        6: t3_overflow <= 1'b1;
        default: t3_cmp_match <= 3'h4;
      endcase
      {t1_tick, t3_tick} <= 2'h3;
      @(posedge clock);
      {t1_cmp_match, t1_overflow, t3_cmp_match, t3_overflow, t1_tick, t3_tick} <= '0;
      t3_capture_input_pin <= 1'b0;
      repeat (3) @(posedge clock);
      rchk(ea[i], 8'h01 << eb[i]);
      chk("irq", 8'h01 << eb[i], i < 3 ? irq_req : ext_irq_req);
      ack_en <= 1'b1;
      slow <= i[0];
      for (int k = 0; k < 30 && (irq_req | ext_irq_req) != 8'h00; k++) @(posedge clock);
      ack_en <= 1'b0;
      rchk(ea[i], 8'h00);
    end
  endtask
  task automatic t_force;
    @(posedge clock);
    t3_cmp_match <= 3'h7;
    t3_force_cmp <= 3'h7;
    t3_tick <= 1'b1;
    @(posedge clock);
    {t3_cmp_match, t3_force_cmp, t3_tick} <= '0;
    repeat (2) @(posedge clock);
    rchk(8'h7C, 8'h00);
    tick1(3'h3, 3'h3, 1'b0);
    repeat (3) @(posedge clock);
    rchk(8'h56, 8'h00);
    tick1(3'h1, 3'h0, 1'b0);
    io_addr <= 8'h56;
    io_wdata <= 8'h10;
    io_we <= 1'b1;
    @(posedge clock);
    io_we <= 1'b0;
    rchk(8'h56, 8'h10);
    global_irq_en <= 1'b0;
    repeat (2) @(negedge clock);
    chk("irq off", 8'h00, irq_req);
    wr(8'h56, 8'h10);
    rchk(8'h56, 8'h00);
  endtask
  task automatic t_capture;
    t1_capture_from_comparator <= 1'b1;
    counter1_value <= 16'hBEEF;
    counter3_value <= 16'h1234;
    @(posedge clock);
    {t1_comparator_out, t3_capture_input_pin} <= 2'h3;
    @(posedge clock);
    {t1_comparator_out, t3_capture_input_pin} <= 2'h0;
    rchk(8'h46, 8'hEF);
    rchk(8'h47, 8'hBE);
    rchk(8'h80, 8'h34);
    rchk(8'h81, 8'h12);
    chk("top1", 8'hBE, capture1_top[15:8]);
    rchk(8'h56, 8'h20);
    wr(8'h56, 8'h20);
    rchk(8'h56, 8'h00);
    wr(8'h81, 8'hAB);
    wr(8'h80, 8'hCD);
    @(negedge clock);
    chk("top3", 8'hAB, capture3_top[15:8]);
    chk("top3", 8'hCD, capture3_top[7:0]);
    wr(8'h7C, 8'h3F);
    t3_top_is_capture <= 1'b1;
    t3_capture_input_pin <= 1'b1;
    @(posedge clock);
    t3_capture_input_pin <= 1'b0;
    t3_counter_at_top <= 1'b1;
    @(posedge clock);
    t3_counter_at_top <= 1'b0;
    rchk(8'h80, 8'hCD);
    rchk(8'h81, 8'hAB);
    rchk(8'h7C, 8'h20);
    t1_capture_from_comparator <= 1'b0;
    counter1_value <= 16'h5678;
    t1_capture_input_pin <= 1'b1;
    @(posedge clock);
    t1_capture_input_pin <= 1'b0;
    rchk(8'h46, 8'h78);
    rchk(8'h47, 8'h56);
    wr(8'h56, 8'h20);
    t1_top_is_capture <= 1'b1;
    t1_counter_at_top <= 1'b1;
    @(posedge clock);
    t1_counter_at_top <= 1'b0;
    rchk(8'h56, 8'h20);
  endtask
  task automatic t_compat;
    compat_mode <= 1'b1;
    repeat (2) @(posedge clock);
    rchk(8'h7D, 8'h00);
    wr(8'h7D, 8'h3F);
    rchk(8'h7D, 8'h00);
    @(negedge clock);
    chk("ext irq", 8'h00, ext_irq_req);
    compat_mode <= 1'b0;
    rchk(8'h7D, 8'h00);
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    {io_addr, io_wdata, io_we, io_re, global_irq_en, compat_mode, ack_en, slow} = '0;
    {counter1_value, counter3_value, t1_capture_input_pin, t3_capture_input_pin} = '0;
    {t1_comparator_out, t1_capture_from_comparator, t1_top_is_capture} = '0;
    {t3_top_is_capture, t1_counter_at_top, t3_counter_at_top, t1_tick, t3_tick} = '0;
    {t1_overflow, t3_overflow, t1_cmp_match, t1_force_cmp, t3_cmp_match, t3_force_cmp} = '0;
    rst_n = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_events();
    t_force();
    t_capture();
    t_compat();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
